// ---- pkg/mrc_pkg.sv ----
// Constants for the mixing routing and clock set-up register block
package mrc_pkg;
  localparam logic [7:0] MRC_ADDR_MODE = 8'h21;
  localparam logic [7:0] MRC_ADDR_LINEOUT = 8'h22;
  localparam logic [7:0] MRC_ADDR_HEADPHONE = 8'h23;
  localparam logic [7:0] MRC_ADDR_SPEAKER = 8'h24;
  localparam logic [7:0] MRC_RESET_VALUE = 8'h00;
  localparam logic [7:0] MRC_MASK_MODE = 8'h33;
  localparam logic [7:0] MRC_MASK_SWITCH = 8'h0f;
  localparam int MRC_BIT_RCV = 0;
  localparam int MRC_BIT_AIN = 1;
  localparam int MRC_BIT_MICL = 4;
  localparam int MRC_BIT_MICR = 5;
  localparam int MRC_BIT_L2 = 0;
  localparam int MRC_BIT_R2 = 1;
  localparam int MRC_BIT_L3 = 2;
  localparam int MRC_BIT_R3 = 3;
  localparam logic [15:0] MRC_SIGN_FLIP = 16'h8000;
  localparam int MRC_CLK_KHZ = 40000;
  localparam int MRC_LOCK_MASTER_MS = 40;
  localparam int MRC_LOCK_FRAME_MS = 160;
  localparam int MRC_LOCK_BIT_MS = 2;
  localparam int MRC_LOCK_MASTER_CYC = MRC_LOCK_MASTER_MS * MRC_CLK_KHZ;
  localparam int MRC_LOCK_FRAME_CYC = MRC_LOCK_FRAME_MS * MRC_CLK_KHZ;
  localparam int MRC_LOCK_BIT_CYC = MRC_LOCK_BIT_MS * MRC_CLK_KHZ;
  localparam int MRC_CNT_W = 24;
endpackage

// ---- tb/mrc_host_ref.sv ----
// Host-side model of the reference clock supply
`timescale 1ns/1ps
module mrc_host_ref (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic supply_on,
  input wire logic stall,
  output logic ref_clock_present
);
  logic present_reg;
  logic present_next;
  // Clock kept running while powered unless a stall is ordered
  always_comb present_next = supply_on && !stall;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst) present_reg <= 1'b0;
    else present_reg <= present_next;
  end
  assign ref_clock_present = present_reg;
endmodule // mrc_host_ref

// ---- tb/mrc_top_chk.sv ----
// Assertion checker for the mixing routing register block
`timescale 1ns/1ps
module mrc_top_chk #(
  parameter int LOCK_MASTER_CYC = 20,
  parameter int LOCK_FRAME_CYC = 40,
  parameter int LOCK_BIT_CYC = 10
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_down_reset_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic pll_power,
  input wire logic master_mode,
  input wire logic pll_ref_is_frame,
  input wire logic ref_clock_present,
  input wire logic [15:0] sample_in,
  input wire logic sample_valid,
  input wire logic receiver_output_select,
  input wire logic stereo_mix_input_select,
  input wire logic left_gain_amp_route,
  input wire logic right_gain_amp_route,
  input wire logic [3:0] lineout_switches,
  input wire logic pll_enable,
  input wire logic pll_locked,
  input wire logic link_clocks_drive,
  input wire logic master_clock_out_valid,
  input wire logic [15:0] dac_level
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  int unsigned wait_reg;
  int unsigned wait_next;
  int lim;
  // Counts only cycles with reference present, since the lock timer pauses otherwise
  always_comb
  begin
    wait_next = wait_reg;
    if (!pll_enable || pll_locked) wait_next = 0;
    else if (ref_clock_present) wait_next = wait_reg + 1;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst) wait_reg <= 0;
    else wait_reg <= wait_next;
  end
  assign lim = master_mode ? LOCK_MASTER_CYC : (pll_ref_is_frame ? LOCK_FRAME_CYC : LOCK_BIT_CYC);
  a_lock_time_bound: assert property (wait_reg <= lim + 3)
    else $error("lock took too long");
  a_lineout_write: assert property (reg_wr_en && power_down_reset_n && reg_addr == 8'h22
    |=> lineout_switches == $past(reg_wdata[3:0])) else $error("line-out switches not written");
  a_mode_write: assert property (reg_wr_en && power_down_reset_n && reg_addr == 8'h21
    |=> {right_gain_amp_route, left_gain_amp_route, stereo_mix_input_select, receiver_output_select}
    == {$past(reg_wdata[5:4]), $past(reg_wdata[1:0])}) else $error("mode bits not written");
  a_stereo_blocks_pll: assert property (stereo_mix_input_select |=> !pll_enable)
    else $error("pll on with stereo mixing input");
  a_pll_power_on: assert property (pll_power && !stereo_mix_input_select && power_down_reset_n
    |=> pll_enable) else $error("pll not enabled");
  a_clocks_after_lock: assert property ($rose(link_clocks_drive) && pll_enable |-> pll_locked)
    else $error("link clocks before lock");
  a_mclk_valid_lock: assert property (master_clock_out_valid |-> pll_locked)
    else $error("master clock valid before lock");
  a_sample_mapping: assert property (sample_valid && power_down_reset_n
    |=> dac_level == ($past(sample_in) ^ 16'h8000)) else $error("sample level wrong");
  a_reserved_read: assert property (reg_rd_en && power_down_reset_n && reg_addr != 8'h21
    |=> reg_rdata[7:4] == 4'h0) else $error("reserved bits not zero");
endmodule // mrc_top_chk
bind mrc_top mrc_top_chk #(.LOCK_MASTER_CYC(LOCK_MASTER_CYC), .LOCK_FRAME_CYC(LOCK_FRAME_CYC),
  .LOCK_BIT_CYC(LOCK_BIT_CYC)) i_chk (.clk, .sys_rst, .power_down_reset_n, .reg_wr_en, .reg_rd_en,
  .reg_addr, .reg_wdata, .reg_rdata, .pll_power, .master_mode, .pll_ref_is_frame, .ref_clock_present,
  .sample_in, .sample_valid, .receiver_output_select, .stereo_mix_input_select, .left_gain_amp_route,
  .right_gain_amp_route, .lineout_switches, .pll_enable, .pll_locked, .link_clocks_drive,
  .master_clock_out_valid, .dac_level);

// ---- tb/mrc_top_test.sv ----
// Self-checking bench for the mixing routing register block
`timescale 1ns/1ps
module mrc_top_test;
  logic clk, sys_rst, power_down_reset_n, reg_wr_en, reg_rd_en, pll_power, master_mode;
  logic pll_ref_is_frame, ref_clock_present, master_clock_out_enable, sample_valid, supply_on, stall;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [15:0] sample_in, dac_level;
  logic recv, stereo, left_r, right_r, pll_enable, pll_locked, link_drv, mco_drv, mco_valid;
  logic [3:0] lineout_sw, hp_sw, spk_sw;
  int fail_count = 0;
  int compares = 0;
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  mrc_host_ref i_host (.clk, .sys_rst, .supply_on, .stall, .ref_clock_present);
  // Short lock counts keep the run brief
  mrc_top #(.LOCK_MASTER_CYC(20), .LOCK_FRAME_CYC(40), .LOCK_BIT_CYC(10)) i_dut (.clk, .sys_rst,
    .power_down_reset_n, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .pll_power,
    .master_mode, .pll_ref_is_frame, .ref_clock_present, .master_clock_out_enable, .sample_in,
    .sample_valid, .receiver_output_select(recv), .stereo_mix_input_select(stereo),
    .left_gain_amp_route(left_r), .right_gain_amp_route(right_r), .lineout_switches(lineout_sw),
    .headphone_switches(hp_sw), .speaker_switches(spk_sw), .pll_enable, .pll_locked,
    .link_clocks_drive(link_drv), .master_clock_out_drive(mco_drv),
    .master_clock_out_valid(mco_valid), .dac_level);
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp);
    @(posedge clk);
  endtask
  task complete_run;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200us;
    fail_count++;
    complete_run;
  end
  initial
  begin
    int n;
    int lim;
    {sys_rst, power_down_reset_n, reg_wr_en, reg_rd_en, pll_power, master_mode} = 6'b110000;
    {pll_ref_is_frame, master_clock_out_enable, sample_valid, supply_on, stall} = 5'b0;
    {reg_addr, reg_wdata, sample_in} = 32'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rd(8'h21 + 8'(i), 8'h00);
    for (int i = 0; i < 4; i++) wr(8'h21 + 8'(i), 8'hff);
    for (int i = 0; i < 4; i++) rd(8'h21 + 8'(i), i == 0 ? 8'h33 : 8'h0f);
    check({right_r, left_r, stereo, recv, lineout_sw, hp_sw, spk_sw}, 16'hffff);
    wr(8'h25, 8'hff);
    rd(8'h25, 8'h00);
    pll_power <= 1'b1;
    repeat (3) @(posedge clk);
    check(pll_enable, 1'b0);
    wr(8'h21, 8'h21);
    check({right_r, left_r, stereo, recv}, 4'h9);
    for (int b = 0; b < 4; b++)
    begin
      wr(8'h22, 8'h01 << b);
      wr(8'h23, 8'h01 << b);
      wr(8'h24, 8'h01 << b);
      check({lineout_sw, hp_sw, spk_sw}, {3{4'h1 << b}});
    end
    for (int m = 0; m < 3; m++)
    begin
      pll_power <= 1'b0;
      master_mode <= (m == 0);
      pll_ref_is_frame <= (m == 1);
      master_clock_out_enable <= (m != 1);
      supply_on <= 1'b1;
      repeat (3) @(posedge clk);
      if (m == 0) check(link_drv, 1'b1);
      pll_power <= 1'b1;
      // Bit reference arrives three cycles after PLL power; timer pauses
      stall <= (m == 2);
      lim = (m == 0) ? 20 : ((m == 1) ? 40 : 13);
      n = 0;
      repeat (3) @(posedge clk);
      stall <= 1'b0;
      @(negedge clk);
      if (m == 0) check({mco_drv, mco_valid, pll_locked}, 3'b100);
      while (pll_locked !== 1'b1 && n < 200)
      begin
        @(negedge clk);
        n++;
      end
      check(16'(n <= lim), 16'h1);
      @(negedge clk);
      if (m == 0) check({link_drv, mco_valid}, 2'b11);
      if (m == 1) check({link_drv, mco_drv, mco_valid}, 3'b000);
      @(posedge clk);
    end
    // Playback runs through the mono mixing input
    check(stereo, 1'b0);
    for (int s = 0; s < 2; s++)
    begin
      sample_in <= s ? 16'h8000 : 16'h7fff;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      @(negedge clk);
      check(dac_level, s ? 16'h0000 : 16'hffff);
      @(posedge clk);
    end
    wr(8'h22, 8'h0f);
    power_down_reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    power_down_reset_n <= 1'b1;
    @(posedge clk);
    rd(8'h22, 8'h00);
    complete_run;
  end
endmodule // mrc_top_test

// ---- verilog/mrc_lock_timer.sv ----
// Down counter that models the settling time of the clock multiplier
`timescale 1ns/1ps
module mrc_lock_timer #(
  parameter int CNT_W = mrc_pkg::MRC_CNT_W
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic run,
  input wire logic [CNT_W-1:0] load_value,
  output logic done
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    count_next = count_reg;
    done_next = done_reg;
    if (start)
    begin
      count_next = load_value;
      done_next = 1'b0;
    end
    else if (run && !done_reg)
    begin
      // Pauses while the reference is missing rather than restarting
      if (count_reg <= {{(CNT_W-1){1'b0}}, 1'b1})
        done_next = 1'b1;
      else
        count_next = count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      count_reg <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule // mrc_lock_timer

// ---- verilog/mrc_top.sv ----
// Mixing routing registers, clock-mode control and sample conversion
//
// Behaviour
// - Receiver bit routes line or receiver output
// - Mixing select mono or stereo; stereo bars PLL
// - Gain-amp route picks third line or amp
// - Four line-out mixing switches, off by default
// - Four headphone mixing switches, off by default
// - Four speaker mixing switches, off by default
// - Samples are two's complement full scale
// - Master-mode lock within 40ms after power
// - Frame and bit clocks driven in master mode only: at once in external mode, after lock in PLL mode
// - Master-clock output invalid until locked
// - Slave lock 160ms frame, 2ms bit reference
// - PLL power bit selects external or PLL mode
`timescale 1ns/1ps
module mrc_top #(
  parameter int LOCK_MASTER_CYC = mrc_pkg::MRC_LOCK_MASTER_CYC,
  parameter int LOCK_FRAME_CYC = mrc_pkg::MRC_LOCK_FRAME_CYC,
  parameter int LOCK_BIT_CYC = mrc_pkg::MRC_LOCK_BIT_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic power_down_reset_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic pll_power,
  input wire logic master_mode,
  input wire logic pll_ref_is_frame,
  input wire logic ref_clock_present,
  input wire logic master_clock_out_enable,
  input wire logic [15:0] sample_in,
  input wire logic sample_valid,
  output logic receiver_output_select,
  output logic stereo_mix_input_select,
  output logic left_gain_amp_route,
  output logic right_gain_amp_route,
  output logic [3:0] lineout_switches,
  output logic [3:0] headphone_switches,
  output logic [3:0] speaker_switches,
  output logic pll_enable,
  output logic pll_locked,
  output logic link_clocks_drive,
  output logic master_clock_out_drive,
  output logic master_clock_out_valid,
  output logic [15:0] dac_level
);
  typedef enum logic [1:0] {MRC_PLL_OFF, MRC_PLL_LOCKING, MRC_PLL_LOCKED} mrc_pll_state_t;

  logic [7:0] mode_reg;
  logic [7:0] mode_next;
  logic [7:0] lineout_reg;
  logic [7:0] lineout_next;
  logic [7:0] headphone_reg;
  logic [7:0] headphone_next;
  logic [7:0] speaker_reg;
  logic [7:0] speaker_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  mrc_pll_state_t pll_state_reg;
  mrc_pll_state_t pll_state_next;
  logic pll_on_reg;
  logic pll_on_next;
  logic drive_reg;
  logic drive_next;
  logic mck_drive_reg;
  logic mck_drive_next;
  logic mck_valid_reg;
  logic mck_valid_next;
  logic locked_reg;
  logic locked_next;
  logic [15:0] level_reg;
  logic [15:0] level_next;
  logic pll_request;
  logic timer_start;
  logic timer_done;
  logic [mrc_pkg::MRC_CNT_W-1:0] lock_load;

  // Register file; power-down pin clears like reset
  always_comb
  begin
    mode_next = mode_reg;
    lineout_next = lineout_reg;
    headphone_next = headphone_reg;
    speaker_next = speaker_reg;
    rdata_next = rdata_reg;
    if (!power_down_reset_n)
    begin
      mode_next = mrc_pkg::MRC_RESET_VALUE;
      lineout_next = mrc_pkg::MRC_RESET_VALUE;
      headphone_next = mrc_pkg::MRC_RESET_VALUE;
      speaker_next = mrc_pkg::MRC_RESET_VALUE;
      rdata_next = 8'h00;
    end
    else
    begin
      if (reg_wr_en)
      begin
        case (reg_addr)
          mrc_pkg::MRC_ADDR_MODE: mode_next = reg_wdata & mrc_pkg::MRC_MASK_MODE;
          mrc_pkg::MRC_ADDR_LINEOUT: lineout_next = reg_wdata & mrc_pkg::MRC_MASK_SWITCH;
          mrc_pkg::MRC_ADDR_HEADPHONE: headphone_next = reg_wdata & mrc_pkg::MRC_MASK_SWITCH;
          mrc_pkg::MRC_ADDR_SPEAKER: speaker_next = reg_wdata & mrc_pkg::MRC_MASK_SWITCH;
          default: ;
        endcase
      end
      if (reg_rd_en)
      begin
        case (reg_addr)
          mrc_pkg::MRC_ADDR_MODE: rdata_next = mode_reg;
          mrc_pkg::MRC_ADDR_LINEOUT: rdata_next = lineout_reg;
          mrc_pkg::MRC_ADDR_HEADPHONE: rdata_next = headphone_reg;
          mrc_pkg::MRC_ADDR_SPEAKER: rdata_next = speaker_reg;
          default: rdata_next = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_reg <= mrc_pkg::MRC_RESET_VALUE;
      lineout_reg <= mrc_pkg::MRC_RESET_VALUE;
      headphone_reg <= mrc_pkg::MRC_RESET_VALUE;
      speaker_reg <= mrc_pkg::MRC_RESET_VALUE;
      rdata_reg <= 8'h00;
    end
    else
    begin
      mode_reg <= mode_next;
      lineout_reg <= lineout_next;
      headphone_reg <= headphone_next;
      speaker_reg <= speaker_next;
      rdata_reg <= rdata_next;
    end
  end

  // Stereo mixing input shares the loop filter pin, so PLL stays off
  assign pll_request = pll_power && !mode_reg[mrc_pkg::MRC_BIT_AIN];

  always_comb
  begin
    if (master_mode)
      lock_load = mrc_pkg::MRC_CNT_W'(LOCK_MASTER_CYC);
    else if (pll_ref_is_frame)
      lock_load = mrc_pkg::MRC_CNT_W'(LOCK_FRAME_CYC);
    else
      lock_load = mrc_pkg::MRC_CNT_W'(LOCK_BIT_CYC);
  end

  assign timer_start = (pll_state_reg == MRC_PLL_OFF) && pll_request;

  mrc_lock_timer #(
    .CNT_W(mrc_pkg::MRC_CNT_W)
  ) u_lock_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(timer_start),
    .run(ref_clock_present),
    .load_value(lock_load),
    .done(timer_done)
  );

  // Clock-mode sequencing
  always_comb
  begin
    pll_state_next = pll_state_reg;
    case (pll_state_reg)
      MRC_PLL_OFF:
        if (pll_request)
          pll_state_next = MRC_PLL_LOCKING;
      MRC_PLL_LOCKING:
        if (!pll_request)
          pll_state_next = MRC_PLL_OFF;
        else if (timer_done)
          pll_state_next = MRC_PLL_LOCKED;
      MRC_PLL_LOCKED:
        if (!pll_request)
          pll_state_next = MRC_PLL_OFF;
      default: pll_state_next = MRC_PLL_OFF;
    endcase
    if (!power_down_reset_n)
      pll_state_next = MRC_PLL_OFF;
    pll_on_next = pll_request && power_down_reset_n;
    // External mode drives at once; PLL mode waits for lock
    drive_next = master_mode && power_down_reset_n
      && (pll_request ? (pll_state_next == MRC_PLL_LOCKED) : !pll_power);
    mck_drive_next = master_clock_out_enable && pll_on_next;
    mck_valid_next = mck_drive_next && (pll_state_next == MRC_PLL_LOCKED);
    // Registered so the lock flag leaves the block glitch free
    locked_next = (pll_state_next == MRC_PLL_LOCKED);
    level_next = level_reg;
    if (sample_valid)
      level_next = sample_in ^ mrc_pkg::MRC_SIGN_FLIP;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pll_state_reg <= MRC_PLL_OFF;
      pll_on_reg <= 1'b0;
      drive_reg <= 1'b0;
      mck_drive_reg <= 1'b0;
      mck_valid_reg <= 1'b0;
      locked_reg <= 1'b0;
      level_reg <= mrc_pkg::MRC_SIGN_FLIP;
    end
    else
    begin
      pll_state_reg <= pll_state_next;
      pll_on_reg <= pll_on_next;
      drive_reg <= drive_next;
      mck_drive_reg <= mck_drive_next;
      mck_valid_reg <= mck_valid_next;
      locked_reg <= locked_next;
      level_reg <= level_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign receiver_output_select = mode_reg[mrc_pkg::MRC_BIT_RCV];
  assign stereo_mix_input_select = mode_reg[mrc_pkg::MRC_BIT_AIN];
  assign left_gain_amp_route = mode_reg[mrc_pkg::MRC_BIT_MICL];
  assign right_gain_amp_route = mode_reg[mrc_pkg::MRC_BIT_MICR];
  assign lineout_switches = lineout_reg[3:0];
  assign headphone_switches = headphone_reg[3:0];
  assign speaker_switches = speaker_reg[3:0];
  assign pll_enable = pll_on_reg;
  assign pll_locked = locked_reg;
  assign link_clocks_drive = drive_reg;
  assign master_clock_out_drive = mck_drive_reg;
  assign master_clock_out_valid = mck_valid_reg;
  assign dac_level = level_reg;
endmodule // mrc_top
